// File: hw/nvm_pkg.sv
// Purpose: shared constants for the data nonvolatile store access unit
// Assumes: 10 MHz system clock, sector 1 register window
// Notes: times are kept in ns, cycle counts derive from the clock period
package nvm_pkg;
   // ==========================================
   // geometry
   localparam int NVM_BYTES = 512;
   localparam int ADDR_W = 9;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_IDX_W = 4;
   localparam logic [3:0] PAGE_LAST = 4'hF;
   // ==========================================
   // register window (sector 1)
   localparam logic [8:0] REG_SECTOR_BASE = 9'h100;
   localparam logic [7:0] OFS_CONTROL = 8'h40;
   localparam logic [7:0] OFS_ADDR_LOW = 8'h41;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h42;
   localparam logic [7:0] OFS_DATA_BYTE = 8'h43;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // ==========================================
   // control bit positions
   localparam int BIT_TIME_SEL = 7;
   localparam int BIT_ERASE_EN = 6;
   localparam int BIT_ERASE_GO = 5;
   localparam int BIT_MODE = 4;
   localparam int BIT_WRITE_EN = 3;
   localparam int BIT_WRITE_GO = 2;
   localparam int BIT_READ_EN = 1;
   localparam int BIT_READ_GO = 0;
   // ==========================================
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_ERASE_SHORT_NS = 3200000;
   localparam int T_WRITE_SHORT_NS = 2200000;
   localparam int T_ERASE_LONG_NS = 3700000;
   localparam int T_WRITE_LONG_NS = 3000000;
   localparam int CYC_ERASE_SHORT = T_ERASE_SHORT_NS / CLK_PERIOD_NS;
   localparam int CYC_WRITE_SHORT = T_WRITE_SHORT_NS / CLK_PERIOD_NS;
   localparam int CYC_ERASE_LONG = T_ERASE_LONG_NS / CLK_PERIOD_NS;
   localparam int CYC_WRITE_LONG = T_WRITE_LONG_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 16;
   // ==========================================
   // cycle state
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_WRITE = 2'b10
   } nvm_state_type;
endpackage

// File: hw/nvm_access.sv
// Purpose: register controlled access unit for a 512 byte data store
// Assumes: registers reached by indirect access into sector 1
// Notes: erase and write are timed in system clock cycles
//
// Overview of operation
// - 512 bytes, nine bit address
// - short select: erase 3.2ms, write 2.2ms
// - long select: erase 3.7ms, write 3.0ms
// - erase needs enable; enable cleared afterwards
// - erase start gated, cleared at end
// - mode picks byte or 16 byte page
// - write needs enable; enable cleared afterwards
// - write start gated, cleared at end
// - read needs enable; never hardware cleared
// - read start gated, cleared when done
// - high address upper bits read zero
// - read byte held in data register
// - page mode low nibble increments, saturates
// - page erase zeroes; byte write erases first
`timescale 1ns/1ns
module nvm_access #(
   parameter int ERASE_SHORT_CYC = nvm_pkg::CYC_ERASE_SHORT,
   parameter int WRITE_SHORT_CYC = nvm_pkg::CYC_WRITE_SHORT,
   parameter int ERASE_LONG_CYC = nvm_pkg::CYC_ERASE_LONG,
   parameter int WRITE_LONG_CYC = nvm_pkg::CYC_WRITE_LONG
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [nvm_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_busy,
   output logic o_done
);
   import nvm_pkg::*;

   // ==========================================
   // parameter check
   localparam int TIMER_MAX = (1 << TIMER_W) - 1;
   generate
      if (ERASE_SHORT_CYC < 1 || ERASE_SHORT_CYC > TIMER_MAX ||
          WRITE_SHORT_CYC < 1 || WRITE_SHORT_CYC > TIMER_MAX ||
          ERASE_LONG_CYC < 1 || ERASE_LONG_CYC > TIMER_MAX ||
          WRITE_LONG_CYC < 1 || WRITE_LONG_CYC > TIMER_MAX) begin : g_bad_time
         $error("cycle counts must lie between 1 and the timer range");
      end
   endgenerate

   localparam logic [TIMER_W-1:0] LD_ERASE_SHORT = TIMER_W'(ERASE_SHORT_CYC - 1);
   localparam logic [TIMER_W-1:0] LD_WRITE_SHORT = TIMER_W'(WRITE_SHORT_CYC - 1);
   localparam logic [TIMER_W-1:0] LD_ERASE_LONG = TIMER_W'(ERASE_LONG_CYC - 1);
   localparam logic [TIMER_W-1:0] LD_WRITE_LONG = TIMER_W'(WRITE_LONG_CYC - 1);

   // ==========================================
   // state
   typedef struct packed {
      logic [NVM_BYTES-1:0][7:0] mem;
      logic [PAGE_BYTES-1:0][7:0] pbuf;
      logic [PAGE_BYTES-1:0] ptag;
      logic [7:0] ctrl;
      logic [7:0] addr_low;
      logic addr_bit8;
      logic [7:0] data;
      logic [7:0] rdata;
      nvm_state_type state;
      logic [TIMER_W-1:0] timer;
      logic done;
   } nvm_regs_type;

   nvm_regs_type q;
   nvm_regs_type d;

   // low nibble step that stops at the page end
   function automatic logic [7:0] step_addr(input logic [7:0] a);
      logic [7:0] r;
      r = a;
      if (a[PAGE_IDX_W-1:0] != PAGE_LAST) begin
         r[PAGE_IDX_W-1:0] = a[PAGE_IDX_W-1:0] + 4'h1;
      end
      return r;
   endfunction

   function automatic logic hit(input logic [8:0] a, input logic [7:0] ofs);
      return a == (REG_SECTOR_BASE | {1'b0, ofs});
   endfunction

   logic [ADDR_W-1:0] cur_addr;
   logic sw_ctrl_wr;
   logic start_erase;
   logic start_write;
   logic start_read;
   logic page_mode;
   logic busy;
   logic [ADDR_W-1:0] slot_addr;

   assign cur_addr = {q.addr_bit8, q.addr_low};
   assign busy = q.state != ST_IDLE;
   assign page_mode = q.ctrl[BIT_MODE];
   assign sw_ctrl_wr = i_reg_wr && hit(i_reg_addr, OFS_CONTROL);
   assign start_erase = sw_ctrl_wr && !busy && i_reg_wdata[BIT_ERASE_GO] &&
      q.ctrl[BIT_ERASE_EN];
   assign start_write = sw_ctrl_wr && !busy && i_reg_wdata[BIT_WRITE_GO] &&
      q.ctrl[BIT_WRITE_EN] && !start_erase;
   assign start_read = sw_ctrl_wr && !busy && i_reg_wdata[BIT_READ_GO] &&
      q.ctrl[BIT_READ_EN] && !i_reg_wdata[BIT_WRITE_GO];

   // ==========================================
   // next state
   always_comb begin
      d = q;
      d.done = 1'b0;
      slot_addr = cur_addr;
      // read start is a one cycle cycle, cleared on the following edge
      d.ctrl[BIT_READ_GO] = 1'b0;
      // register read data
      d.rdata = RESET_BYTE;
      if (i_reg_rd) begin
         if (hit(i_reg_addr, OFS_CONTROL)) begin
            d.rdata = q.ctrl;
         end else if (hit(i_reg_addr, OFS_ADDR_LOW)) begin
            d.rdata = q.addr_low;
         end else if (hit(i_reg_addr, OFS_ADDR_HIGH)) begin
            d.rdata = {7'h00, q.addr_bit8};
         end else if (hit(i_reg_addr, OFS_DATA_BYTE)) begin
            d.rdata = q.data;
         end
      end
      // timed cycle and its completion
      unique case (q.state)
         ST_IDLE: begin
         end
         ST_ERASE: begin
            if (q.timer != '0) begin
               d.timer = q.timer - 1'b1;
            end else begin
               for (int i = 0; i < PAGE_BYTES; i++) begin
                  slot_addr = {cur_addr[ADDR_W-1:PAGE_IDX_W], PAGE_IDX_W'(i)};
                  if (page_mode ? q.ptag[i] : (slot_addr == cur_addr)) begin
                     d.mem[slot_addr] = RESET_BYTE;
                  end
               end
               d.ctrl[BIT_ERASE_GO] = 1'b0;
               d.ctrl[BIT_ERASE_EN] = 1'b0;
               // enable falling to zero also empties the page buffer tags
               d.ptag = '0;
               d.done = 1'b1;
               d.state = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (q.timer != '0) begin
               d.timer = q.timer - 1'b1;
            end else begin
               if (page_mode) begin
                  for (int i = 0; i < PAGE_BYTES; i++) begin
                     slot_addr = {cur_addr[ADDR_W-1:PAGE_IDX_W], PAGE_IDX_W'(i)};
                     if (q.ptag[i]) begin
                        d.mem[slot_addr] = q.pbuf[i];
                     end
                  end
                  d.ptag = '0;
               end else begin
                  // byte erased then written in one timed cycle
                  d.mem[cur_addr] = q.data;
               end
               d.ctrl[BIT_WRITE_GO] = 1'b0;
               d.ctrl[BIT_WRITE_EN] = 1'b0;
               d.done = 1'b1;
               d.state = ST_IDLE;
            end
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase
      // software writes
      if (i_reg_wr && !busy) begin
         if (hit(i_reg_addr, OFS_CONTROL)) begin
            d.ctrl = i_reg_wdata;
            d.ctrl[BIT_ERASE_GO] = start_erase;
            d.ctrl[BIT_WRITE_GO] = start_write;
            d.ctrl[BIT_READ_GO] = 1'b0;
            if (q.ctrl[BIT_ERASE_EN] && !i_reg_wdata[BIT_ERASE_EN]) begin
               d.ptag = '0;
            end
         end else if (hit(i_reg_addr, OFS_ADDR_LOW)) begin
            d.addr_low = i_reg_wdata;
         end else if (hit(i_reg_addr, OFS_ADDR_HIGH)) begin
            d.addr_bit8 = i_reg_wdata[0];
         end else if (hit(i_reg_addr, OFS_DATA_BYTE)) begin
            d.data = i_reg_wdata;
            if (page_mode) begin
               // page mode data writes tag a slot and fill the buffer
               d.pbuf[q.addr_low[PAGE_IDX_W-1:0]] = i_reg_wdata;
               d.ptag[q.addr_low[PAGE_IDX_W-1:0]] = 1'b1;
               d.addr_low = step_addr(q.addr_low);
            end
         end
      end
      if (start_erase) begin
         d.state = ST_ERASE;
         d.timer = q.ctrl[BIT_TIME_SEL] ? LD_ERASE_LONG : LD_ERASE_SHORT;
      end else if (start_write) begin
         d.state = ST_WRITE;
         d.timer = q.ctrl[BIT_TIME_SEL] ? LD_WRITE_LONG : LD_WRITE_SHORT;
      end else if (start_read) begin
         d.ctrl[BIT_READ_GO] = 1'b1;
         d.data = q.mem[cur_addr];
         if (page_mode) begin
            d.addr_low = step_addr(q.addr_low);
         end
      end
      // synchronous reset; store contents are nonvolatile and kept
      if (!i_rst_n) begin
         d.pbuf = '0;
         d.ptag = '0;
         d.ctrl = RESET_BYTE;
         d.addr_low = RESET_BYTE;
         d.addr_bit8 = 1'b0;
         d.data = RESET_BYTE;
         d.rdata = RESET_BYTE;
         d.state = ST_IDLE;
         d.timer = '0;
         d.done = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      q <= d;
   end

   assign o_reg_rdata = q.rdata;
   assign o_busy = busy;
   assign o_done = q.done;

   // ==========================================
   // assertions
   sequence erase_begins;
      q.state == ST_IDLE ##1 q.state == ST_ERASE;
   endsequence

   sequence write_begins;
      q.state == ST_IDLE ##1 q.state == ST_WRITE;
   endsequence

   AST_ERASE_GATED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      erase_begins |-> $past(q.ctrl[BIT_ERASE_EN]) && q.ctrl[BIT_ERASE_GO])
      else $error("erase began without erase enable");

   AST_WRITE_GATED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      write_begins |-> $past(q.ctrl[BIT_WRITE_EN]) && q.ctrl[BIT_WRITE_GO])
      else $error("write began without write enable");

   AST_ERASE_TIME: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      erase_begins |-> q.timer == ($past(q.ctrl[BIT_TIME_SEL]) ?
         LD_ERASE_LONG : LD_ERASE_SHORT))
      else $error("erase timer loaded with wrong count");

   AST_WRITE_TIME: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      write_begins |-> q.timer == ($past(q.ctrl[BIT_TIME_SEL]) ?
         LD_WRITE_LONG : LD_WRITE_SHORT))
      else $error("write timer loaded with wrong count");

   AST_ERASE_END: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (q.state == ST_ERASE && q.timer == '0) |=>
         q.state == ST_IDLE && o_done && !q.ctrl[BIT_ERASE_EN] && !q.ctrl[BIT_ERASE_GO])
      else $error("erase end did not clear its bits");

   AST_WRITE_END: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (q.state == ST_WRITE && q.timer == '0) |=>
         q.state == ST_IDLE && o_done && !q.ctrl[BIT_WRITE_EN] && !q.ctrl[BIT_WRITE_GO])
      else $error("write end did not clear its bits");

   AST_DONE_ONLY_AT_END: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_done |-> $past(q.state) != ST_IDLE && q.state == ST_IDLE)
      else $error("completion pulse without a finishing cycle");

   AST_READ_ONE_CYCLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(q.ctrl[BIT_READ_GO]) |-> $past(q.ctrl[BIT_READ_EN]) ##1 !q.ctrl[BIT_READ_GO])
      else $error("read start not gated or not cleared");

   AST_READ_DATA: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      start_read |=> q.data == $past(q.mem[cur_addr]))
      else $error("read byte not placed in data register");

   AST_HIGH_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_reg_rd && hit(i_reg_addr, OFS_ADDR_HIGH)) |=> o_reg_rdata[7:1] == 7'h00)
      else $error("high address upper bits not zero");

   AST_SATURATE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (start_read && page_mode && q.addr_low[PAGE_IDX_W-1:0] == PAGE_LAST) |=>
         q.addr_low == $past(q.addr_low))
      else $error("page address rolled over");
endmodule

// File: verification/nvm_host.sv
// Purpose: software side model that reaches the registers through sector 1
// Assumes: strobes and address change at the falling edge, taken at the rising edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ns
module nvm_host (
   input wire logic i_mclk,
   input wire logic i_busy,
   output logic [nvm_pkg::ADDR_W-1:0] o_reg_addr,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_wdata
);
   import nvm_pkg::*;
   // ==========================================
   // idle levels
   initial begin
      o_reg_addr = '0;
      o_reg_wr = 1'h0;
      o_reg_rd = 1'h0;
      o_reg_wdata = 8'h00;
   end
   // ==========================================
   // one register access, sector 1 or sector 0
   task automatic cycle(input logic sec, input logic [7:0] ofs, input logic [7:0] d,
                        input logic wr);
      @(negedge i_mclk);
      o_reg_addr = sec ? (REG_SECTOR_BASE | {1'h0, ofs}) : {1'h0, ofs};
      o_reg_wdata = d;
      o_reg_wr = wr;
      o_reg_rd = !wr;
      @(negedge i_mclk);
      o_reg_wr = 1'h0;
      o_reg_rd = 1'h0;
      o_reg_addr = ~o_reg_addr;
      o_reg_wdata = ~o_reg_wdata;
   endtask
   // ==========================================
   // enable first, then enable with start; sub clock taken as stable, no input for it
   task automatic go(input logic [7:0] en, input logic [7:0] start);
      cycle(1'h1, OFS_CONTROL, en, 1'h1);
      cycle(1'h1, OFS_CONTROL, en | start, 1'h1);
   endtask
   // ==========================================
   // wait for a running erase or write to end
   task automatic wait_idle();
      repeat (200) if (i_busy === 1'h1) @(negedge i_mclk);
   endtask
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench for the store access unit
// Assumes: shortened cycle times through the parameters
// Notes: reads are checked against a queue of expected bytes
`timescale 1ns/1ns
module tb;
   import nvm_pkg::*;
   localparam int ES = 8;
   localparam int WS = 5;
   localparam int EL = 10;
   localparam int WL = 6;
   logic i_mclk = 1'h0;
   logic i_rst_n = 1'h0;
   logic [ADDR_W-1:0] i_reg_addr;
   logic i_reg_wr, i_reg_rd, o_busy, o_done, rd_pend = 1'h0, sel, ers;
   logic [7:0] i_reg_wdata, o_reg_rdata, a, d, en, st, ts;
   logic [7:0] exp_q[$];
   logic [7:0] pdat[2];
   logic [7:0] bad_starts[3] = '{8'h04, 8'h20, 8'h01};
   logic [31:0] seed = 32'h00012E6D;
   int err_total = 0, n_compared = 0, busy_cnt = 0, done_cnt = 0, n;
   always #50 i_mclk = ~i_mclk;
   nvm_access #(.ERASE_SHORT_CYC(ES), .WRITE_SHORT_CYC(WS), .ERASE_LONG_CYC(EL),
                .WRITE_LONG_CYC(WL)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_busy(o_busy), .o_done(o_done));
   nvm_host host (.i_mclk(i_mclk), .i_busy(o_busy), .o_reg_addr(i_reg_addr),
      .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata));
   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic c, input string m);
      n_compared++;
      if (!c) begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] o, input logic [7:0] v);
      host.cycle(1'h1, o, v, 1'h1);
   endtask
   task automatic rd(input logic [7:0] o, input logic [7:0] e);
      exp_q.push_back(e);
      host.cycle(1'h1, o, 8'h00, 1'h0);
   endtask
   task automatic final_report();
      if (err_total == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========================================
   // monitors
   always @(posedge i_mclk) rd_pend <= i_reg_rd;
   always @(negedge i_mclk) begin
      if (o_busy === 1'h1) busy_cnt++;
      if (o_done === 1'h1) done_cnt++;
      if (rd_pend) begin
         n_compared++;
         if (exp_q.size() == 0 || o_reg_rdata !== exp_q.pop_front()) begin
            err_total++;
            $display("[ERR] %0t read data %h", $time, o_reg_rdata);
         end
      end else if (o_reg_rdata !== 8'h00) begin
         err_total++;
         $display("[ERR] %0t read data not idle", $time);
      end
   end
   initial begin
      #(20000 * 100);
      err_total++;
      final_report();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst_n = 1'h1;
      for (int i = 0; i < 4; i++) rd(OFS_CONTROL + i[7:0], 8'h00);
      rd(8'h44, 8'h00);
      wr(OFS_ADDR_HIGH, 8'hFF);
      rd(OFS_ADDR_HIGH, 8'h01);
      foreach (bad_starts[i]) begin
         wr(OFS_DATA_BYTE, 8'h5A);
         wr(OFS_CONTROL, bad_starts[i]);
         check(o_busy === 1'h0, "start without enable");
         rd(OFS_CONTROL, 8'h00);
         rd(OFS_DATA_BYTE, 8'h5A);
      end
      for (int k = 0; k < 4; k++) begin
         sel = k[0];
         ers = k[1];
         seed = lfsr(seed);
         a = seed[7:0];
         seed = lfsr(seed);
         d = seed[7:0];
         ts = {sel, 7'h00};
         en = ers ? 8'h40 : 8'h08;
         st = ers ? 8'h20 : 8'h04;
         n = ers ? (sel ? EL : ES) : (sel ? WL : WS);
         wr(OFS_ADDR_LOW, a);
         wr(OFS_DATA_BYTE, d);
         busy_cnt = 0;
         done_cnt = 0;
         host.go(ts | en, st);
         wr(OFS_ADDR_LOW, ~a);
         host.wait_idle();
         repeat (2) @(negedge i_mclk);
         check(busy_cnt == n, "cycle length");
         check(done_cnt == 1, "completion pulse");
         rd(OFS_CONTROL, ts);
         rd(OFS_ADDR_LOW, a);
         wr(OFS_CONTROL, ts | 8'h02);
         wr(OFS_CONTROL, ts | 8'h03);
         rd(OFS_DATA_BYTE, ers ? 8'h00 : d);
         rd(OFS_CONTROL, ts | 8'h02);
      end
      for (int i = 0; i < 2; i++) begin
         seed = lfsr(seed);
         pdat[i] = seed[7:0];
         wr(OFS_ADDR_LOW, 8'h3E + i[7:0]);
         wr(OFS_DATA_BYTE, pdat[i]);
         host.go(8'h08, 8'h04);
         host.wait_idle();
      end
      wr(OFS_ADDR_LOW, 8'h3E);
      wr(OFS_CONTROL, 8'h12);
      exp_q.push_back(8'h00);
      host.cycle(1'h0, OFS_CONTROL, 8'h00, 1'h0);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CONTROL, 8'h13);
         rd(OFS_DATA_BYTE, pdat[i]);
         rd(OFS_ADDR_LOW, 8'h3F);
      end
      rd(OFS_ADDR_HIGH, 8'h01);
      @(negedge i_mclk);
      i_rst_n = 1'h0;
      repeat (2) @(negedge i_mclk);
      i_rst_n = 1'h1;
      rd(OFS_CONTROL, 8'h00);
      rd(OFS_ADDR_LOW, 8'h00);
      repeat (3) @(negedge i_mclk);
      check(exp_q.size() == 0, "reads outstanding");
      final_report();
   end
endmodule
